// >>> verilog/ssc_pkg.sv
/*
  Package of the serial sync-clock and smart card receive block: register
  indices, field positions, reset values, carrier structs and timing counts.
  Assumes a single 40 MHz system clock and an 8-bit register port.
*/
package ssc_pkg;
  // Register indices on the plain register port
  localparam logic [3:0] SSC_CTRL_IDX   = 4'h0;
  localparam logic [3:0] SSC_STAT_IDX   = 4'h1;
  localparam logic [3:0] SSC_TXD_IDX    = 4'h2;
  localparam logic [3:0] SSC_RXD_IDX    = 4'h3;
  localparam logic [3:0] SSC_BAUD_IDX   = 4'h4;
  localparam logic [3:0] SSC_ISTAT_IDX  = 4'h5;
  localparam logic [3:0] SSC_IMASK_IDX  = 4'h6;
  // Status field positions
  localparam int SSC_RECEIVE_FULL_FLAG_BIT = 0;
  localparam int SSC_PER_BIT  = 1;
  localparam int SSC_OVERRUN_ERROR_FLAG_BIT = 2;
  localparam int SSC_TDRE_BIT = 3;
  // Event field positions in the interrupt status and mask
  localparam int SSC_EV_RXFULL = 0;
  localparam int SSC_EV_PARITY = 1;
  localparam int SSC_EV_OVERRUN = 2;
  localparam int SSC_EV_TXDONE = 3;
  // Reset values
  localparam logic [7:0] SSC_CTRL_RST  = 8'h00;
  localparam logic [7:0] SSC_BAUD_RST  = 8'h03;
  localparam logic [3:0] SSC_IMASK_RST = 4'h0;
  // Character and frame counts
  localparam logic [3:0] SSC_SYNC_BITS = 4'h8;
  localparam logic [3:0] SSC_SC_BITS   = 4'h9;
  localparam logic [3:0] SSC_OVERSAMP  = 4'hF;

  typedef struct packed {
    logic [1:0] spare;
    logic       receive_irq_enable;
    logic       rx_enable;
    logic       tx_enable;
    logic       smart_mode;
    logic       clock_source_select_hi;
    logic       clock_source_select_lo;
  } ssc_ctrl_t;

  typedef struct packed {
    logic tdre;
    logic overrun_error_flag;
    logic parity_error_flag;
    logic receive_full_flag;
  } ssc_stat_t;
endpackage

// >>> verilog/ssc_top.sv
/*
  Serial communication unit slice: clocked synchronous transfer with an
  internal or external synchronization clock, and smart card character
  reception with parity checking, flags and interrupt requests.
  Assumes a register master that keeps the plain strobe protocol, and pins
  that are asynchronous to clk_sys_i.
*/
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Clock source chosen by the high select bit only
// - Internal clock driven out on clock pin
// - Eight clock pulses per character
// - Clock output held high when idle
// - Parity error sets flag, error interrupt
// - Parity-error frame leaves receive-full unset
// - Good character sets receive-full, data interrupt
// - Overrun or parity raises error interrupt
// - Card data reaches receive register despite error
// - Shift out on fall, sample on rise
// - Eight data bits, line holds MSB
module ssc_top
  import ssc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       sys_rst_i,
  // Register port
  input  wire logic [3:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  // Serial pins
  input  wire logic       sck_i,
  output logic            sck_o,
  output logic            sck_oe_n_o,
  input  wire logic       rxd_i,
  output logic            txd_o,
  // Interrupt requests
  output logic            receive_data_irq_o,
  output logic            receive_error_irq_o,
  output logic            irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic sck_m_q, sck_s_q, sck_p_q, rxd_m_q, rxd_s_q;
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sck_m_q <= 1'b1;
      sck_s_q <= 1'b1;
      sck_p_q <= 1'b1;
      rxd_m_q <= 1'b1;
      rxd_s_q <= 1'b1;
    end else begin
      sck_m_q <= sck_i;
      sck_s_q <= sck_m_q;
      sck_p_q <= sck_s_q;
      rxd_m_q <= rxd_i;
      rxd_s_q <= rxd_m_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  ssc_ctrl_t  ctrl_q, ctrl_d;
  ssc_stat_t  stat_q, stat_d;
  logic [7:0] baud_q, baud_d, tdr_q, tdr_d, rdr_q, rdr_d, rdata_q, rdata_d;
  logic [3:0] istat_q, istat_d, imask_q, imask_d;
  logic [2:0] armed_q, armed_d;
  logic       rx_irq_q, rx_irq_d, er_irq_q, er_irq_d, irq_q, irq_d;
  // Events from the engines
  logic       sync_start, sync_done, sc_done, par_err;
  logic [7:0] sync_rx_data, sc_data;
  logic       int_clk;

  assign int_clk = ~ctrl_q.clock_source_select_hi;

  always_comb begin
    logic rx_done;
    logic [7:0] rx_byte;
    logic [3:0] ev;
    rx_done = sync_done & ctrl_q.rx_enable;
    rx_byte = sc_done ? sc_data : sync_rx_data;
    ev      = 4'h0;
    ctrl_d  = ctrl_q;
    stat_d  = stat_q;
    baud_d  = baud_q;
    tdr_d   = tdr_q;
    rdr_d   = rdr_q;
    istat_d = istat_q;
    imask_d = imask_q;
    armed_d = armed_q;
    rdata_d = 8'h00;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        SSC_CTRL_IDX:  rdata_d = ctrl_q;
        SSC_STAT_IDX:  rdata_d = {4'h0, stat_q};
        SSC_TXD_IDX:   rdata_d = tdr_q;
        SSC_RXD_IDX:   rdata_d = rdr_q;
        SSC_BAUD_IDX:  rdata_d = baud_q;
        SSC_ISTAT_IDX: rdata_d = {4'h0, istat_q};
        SSC_IMASK_IDX: rdata_d = {4'h0, imask_q};
        default:       rdata_d = 8'h00;
      endcase
      if (reg_addr_i == SSC_STAT_IDX) begin
        armed_d = armed_q | {stat_q.overrun_error_flag, stat_q.parity_error_flag, stat_q.receive_full_flag};
      end
    end
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        SSC_CTRL_IDX:  ctrl_d = reg_wdata_i;
        SSC_TXD_IDX: begin
          tdr_d       = reg_wdata_i;
          stat_d.tdre = 1'b0;
        end
        SSC_BAUD_IDX:  baud_d = reg_wdata_i;
        SSC_ISTAT_IDX: istat_d = istat_q & ~reg_wdata_i[3:0];
        SSC_IMASK_IDX: imask_d = reg_wdata_i[3:0];
        SSC_STAT_IDX: begin
          // zero after read clears, one keeps
          for (int i = 0; i < 3; i++) begin
            if (armed_q[i] && !reg_wdata_i[i]) begin
              stat_d[i]  = 1'b0;
              armed_d[i] = 1'b0;
            end
          end
        end
        default: ;
      endcase
    end
    if (sync_start && ctrl_q.tx_enable) begin
      stat_d.tdre = 1'b1;
    end
    // Hardware sets below win over a clear in the same cycle
    if (sc_done) begin
      // data kept even on parity error
      rdr_d = rx_byte;
      if (par_err) begin
        stat_d.parity_error_flag = 1'b1;
        ev[SSC_EV_PARITY] = 1'b1;
      end else if (stat_q.receive_full_flag) begin
        stat_d.overrun_error_flag = 1'b1;
        ev[SSC_EV_OVERRUN] = 1'b1;
      end else begin
        stat_d.receive_full_flag = 1'b1;
        ev[SSC_EV_RXFULL] = 1'b1;
      end
    end else if (rx_done) begin
      if (stat_q.receive_full_flag) begin
        stat_d.overrun_error_flag = 1'b1;
        ev[SSC_EV_OVERRUN] = 1'b1;
      end else begin
        rdr_d = rx_byte;
        stat_d.receive_full_flag = 1'b1;
        ev[SSC_EV_RXFULL] = 1'b1;
      end
    end
    ev[SSC_EV_TXDONE] = sync_done & ctrl_q.tx_enable;
    istat_d  = istat_d | ev;
    rx_irq_d = stat_q.receive_full_flag & ctrl_q.receive_irq_enable;
    // either error flag requests the error interrupt
    er_irq_d = (stat_q.parity_error_flag | stat_q.overrun_error_flag) & ctrl_q.receive_irq_enable;
    irq_d    = |(istat_q & imask_q);
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ctrl_q   <= SSC_CTRL_RST;
      stat_q   <= 4'h8;
      baud_q   <= SSC_BAUD_RST;
      tdr_q    <= 8'h00;
      rdr_q    <= 8'h00;
      istat_q  <= 4'h0;
      imask_q  <= SSC_IMASK_RST;
      armed_q  <= 3'h0;
      rdata_q  <= 8'h00;
      rx_irq_q <= 1'b0;
      er_irq_q <= 1'b0;
      irq_q    <= 1'b0;
    end else begin
      ctrl_q   <= ctrl_d;
      stat_q   <= stat_d;
      baud_q   <= baud_d;
      tdr_q    <= tdr_d;
      rdr_q    <= rdr_d;
      istat_q  <= istat_d;
      imask_q  <= imask_d;
      armed_q  <= armed_d;
      rdata_q  <= rdata_d;
      rx_irq_q <= rx_irq_d;
      er_irq_q <= er_irq_d;
      irq_q    <= irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clocked synchronous engine
  typedef enum logic {SY_IDLE, SY_SHIFT} ssc_sy_state_t;
  ssc_sy_state_t sy_q, sy_d;
  logic [7:0] div_q, div_d, txsh_q, txsh_d, rxsh_q, rxsh_d;
  logic [3:0] nbit_q, nbit_d;
  logic       sck_q, sck_d, txd_q, txd_d, oen_q, oen_d;
  logic       fall_e, rise_e;

  // Sync mode only; receive-only runs while the data register is free
  assign sync_start = (sy_q == SY_IDLE) && !ctrl_q.smart_mode
                      && ((ctrl_q.tx_enable && !stat_q.tdre)
                          || (ctrl_q.rx_enable && !ctrl_q.tx_enable && !stat_q.receive_full_flag));
  assign fall_e = int_clk ? (sck_q && div_q == 8'h00 && sy_q == SY_SHIFT) : (sck_p_q && !sck_s_q);
  assign rise_e = int_clk ? (!sck_q && div_q == 8'h00 && sy_q == SY_SHIFT) : (!sck_p_q && sck_s_q);
  assign sync_done    = (sy_q == SY_SHIFT) && rise_e && nbit_q == SSC_SYNC_BITS - 4'h1;
  assign sync_rx_data = {rxd_s_q, rxsh_q[7:1]};

  always_comb begin
    sy_d   = sy_q;
    div_d  = div_q;
    txsh_d = txsh_q;
    rxsh_d = rxsh_q;
    nbit_d = nbit_q;
    sck_d  = sck_q;
    txd_d  = txd_q;
    // drive the pin only on the internal clock
    oen_d  = ~int_clk;
    unique case (sy_q)
      SY_IDLE: begin
        sck_d = 1'b1;
        div_d = baud_q;
        if (sync_start) begin
          sy_d   = SY_SHIFT;
          txsh_d = tdr_q;
          nbit_d = 4'h0;
        end
      end
      SY_SHIFT: begin
        if (int_clk) begin
          div_d = (div_q == 8'h00) ? baud_q : div_q - 8'h01;
          if (div_q == 8'h00) begin
            sck_d = ~sck_q;
          end
        end
        // drive on fall, LSB first, MSB holds
        if (fall_e) begin
          txd_d  = txsh_q[0];
          txsh_d = {1'b0, txsh_q[7:1]};
        end
        // sample on rise, eight per character
        if (rise_e) begin
          rxsh_d = {rxd_s_q, rxsh_q[7:1]};
          nbit_d = nbit_q + 4'h1;
          if (sync_done) begin
            sy_d = SY_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sy_q   <= SY_IDLE;
      div_q  <= 8'h00;
      txsh_q <= 8'h00;
      rxsh_q <= 8'h00;
      nbit_q <= 4'h0;
      sck_q  <= 1'b1;
      txd_q  <= 1'b1;
      oen_q  <= 1'b1;
    end else begin
      sy_q   <= sy_d;
      div_q  <= div_d;
      txsh_q <= txsh_d;
      rxsh_q <= rxsh_d;
      nbit_q <= nbit_d;
      sck_q  <= sck_d;
      txd_q  <= txd_d;
      oen_q  <= oen_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Smart card receiver: start, 8 data LSB first, even parity
  typedef enum logic [1:0] {SC_IDLE, SC_START, SC_BITS} ssc_sc_state_t;
  ssc_sc_state_t sc_q, sc_d;
  logic [11:0] etu_q, etu_d;
  logic [8:0]  scsh_q, scsh_d;
  logic [3:0]  scn_q, scn_d;
  logic [11:0] bit_len;

  // Bit time is sixteen ticks of the baud divider
  assign bit_len = {baud_q, SSC_OVERSAMP};
  assign sc_done = (sc_q == SC_BITS) && etu_q == 12'h000 && scn_q == SSC_SC_BITS - 4'h1;
  assign sc_data = scsh_q[8:1];
  assign par_err = ^{rxd_s_q, scsh_q[8:1]};

  always_comb begin
    sc_d   = sc_q;
    etu_d  = (etu_q == 12'h000) ? bit_len : etu_q - 12'h001;
    scsh_d = scsh_q;
    scn_d  = scn_q;
    unique case (sc_q)
      SC_IDLE: begin
        etu_d = {1'b0, bit_len[11:1]};
        if (ctrl_q.smart_mode && ctrl_q.rx_enable && !rxd_s_q) begin
          sc_d = SC_START;
        end
      end
      SC_START: begin
        if (etu_q == 12'h000) begin
          sc_d  = rxd_s_q ? SC_IDLE : SC_BITS;
          scn_d = 4'h0;
        end
      end
      SC_BITS: begin
        if (etu_q == 12'h000) begin
          scsh_d = {rxd_s_q, scsh_q[8:1]};
          scn_d  = scn_q + 4'h1;
          if (sc_done) begin
            sc_d = SC_IDLE;
          end
        end
      end
      default: sc_d = SC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sc_q   <= SC_IDLE;
      etu_q  <= 12'h000;
      scsh_q <= 9'h000;
      scn_q  <= 4'h0;
    end else begin
      sc_q   <= sc_d;
      etu_q  <= etu_d;
      scsh_q <= scsh_d;
      scn_q  <= scn_d;
    end
  end

  assign reg_rdata_o         = rdata_q;
  assign sck_o               = sck_q;
  assign sck_oe_n_o          = oen_q;
  assign txd_o               = txd_q;
  assign receive_data_irq_o  = rx_irq_q;
  assign receive_error_irq_o = er_irq_q;
  assign irq_o               = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [3:0] pulses_q;
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || sync_start) begin
      pulses_q <= 4'h0;
    end else if (int_clk && fall_e) begin
      pulses_q <= pulses_q + 4'h1;
    end
  end

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  sequence bad_char_s;
    sc_done && par_err;
  endsequence
  sequence good_char_s;
    sc_done && !par_err && !stat_q.receive_full_flag;
  endsequence

  src_sel_a: assert property (ctrl_q.clock_source_select_hi |=> sck_oe_n_o)
    else $error("clock pin driven with external source");
  int_drive_a: assert property (!ctrl_q.clock_source_select_hi && $stable(ctrl_q) |=> !sck_oe_n_o)
    else $error("internal clock not driven out");
  eight_pulses_a: assert property (int_clk && sync_done |-> pulses_q == 4'h8)
    else $error("wrong clock pulse count");
  idle_high_a: assert property (sy_q == SY_IDLE && $past(sy_q) == SY_IDLE |-> sck_o)
    else $error("clock not high while idle");
  per_set_a: assert property (bad_char_s |=> stat_q.parity_error_flag ##1 stat_q.parity_error_flag)
    else $error("parity flag not set");
  per_no_full_a: assert property (bad_char_s and !stat_q.receive_full_flag |=> !stat_q.receive_full_flag)
    else $error("receive-full set on parity error");
  good_full_a: assert property (good_char_s |=> stat_q.receive_full_flag && !$rose(stat_q.parity_error_flag))
    else $error("good character not flagged");
  err_irq_a: assert property ((stat_q.parity_error_flag || stat_q.overrun_error_flag)
                              && ctrl_q.receive_irq_enable |=> receive_error_irq_o)
    else $error("error interrupt missing");
  rdr_load_a: assert property (sc_done |=> rdr_q == $past(sc_data))
    else $error("received data not stored");
  tx_on_fall_a: assert property (fall_e && sy_q == SY_SHIFT |=> txd_o == $past(txsh_q[0]))
    else $error("transmit bit not driven on fall");
  one_keeps_a: assert property (reg_wr_i && reg_addr_i == SSC_STAT_IDX && reg_wdata_i[SSC_PER_BIT]
                                && stat_q.parity_error_flag |=> stat_q.parity_error_flag)
    else $error("write of one cleared flag");

endmodule

`default_nettype wire

// >>> tb/ssc_peer_model.sv
/*
  Far-side model: a smart card sending characters on the data line and a
  clocked serial peer capturing transmit bits on the rising clock edge.
  Assumes it shares the block's system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module ssc_peer_model #(
  parameter int BIT_CYC = 64
) (
  // Clock
  input  wire logic       clk_i,
  // Serial lines
  input  wire logic       sck_i,
  input  wire logic       txd_i,
  output logic            rxd_o,
  // Observation
  output logic [7:0]      cap_o,
  output logic [3:0]      rise_cnt_o
);
  logic sck_q;

  initial begin
    rxd_o = 1'b1;
    cap_o = 8'h00;
    rise_cnt_o = 4'h0;
    sck_q = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // LSB first, taken on rise
  always @(posedge clk_i) begin
    sck_q <= sck_i;
    if (!sck_q && sck_i) begin
      cap_o <= {txd_i, cap_o[7:1]};
      rise_cnt_o <= rise_cnt_o + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Start, eight data bits, even parity; line is pulled up afterwards
  task automatic send_char(input logic [7:0] d, input logic bad);
    logic [9:0] f;
    f = {(^d) ^ bad, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd_o <= f[i];
      repeat (BIT_CYC) @(posedge clk_i);
    end
    rxd_o <= 1'b1;
  endtask
endmodule
`default_nettype wire

// >>> tb/ssc_tb_top.sv
/*
  Self-checking bench of the sync-clock and smart card receive block.
  Assumes reset baud divisor 3: 4-cycle half clock, 64-cycle card bit.
*/
`timescale 1ns/1ps
`default_nettype none
module ssc_tb_top;
  import ssc_pkg::*;
  logic       clk_sys_i;
  logic       sys_rst_i;
  logic [3:0] reg_addr_i;
  logic [7:0] reg_wdata_i;
  logic       reg_wr_i;
  logic       reg_rd_i;
  logic [7:0] reg_rdata_o;
  logic       sck_i;
  logic       sck_o;
  logic       sck_oe_n_o;
  logic       rxd_i;
  logic       txd_o;
  logic       rdi;
  logic       rei;
  logic       irq_o;
  logic [7:0] cap;
  logic [3:0] rises;
  int         err_count;
  int         n_tests;
  int         cyc;

  ssc_top dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .sck_i(sck_i),
    .sck_o(sck_o), .sck_oe_n_o(sck_oe_n_o), .rxd_i(rxd_i), .txd_o(txd_o),
    .receive_data_irq_o(rdi), .receive_error_irq_o(rei), .irq_o(irq_o));

  ssc_peer_model #(.BIT_CYC(64)) card (.clk_i(clk_sys_i), .sck_i(sck_o),
    .txd_i(txd_o), .rxd_o(rxd_i), .cap_o(cap), .rise_cnt_o(rises));

  always #12.5 clk_sys_i = ~clk_sys_i;

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    @(negedge clk_sys_i);
    d = reg_rdata_o;
  endtask

  task automatic rdc(input logic [3:0] a, input logic [7:0] exp, input string m);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp, m);
  endtask

  task automatic wrap_up;
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdc(SSC_CTRL_IDX, 8'h00, "ctrl rst");
    rdc(SSC_STAT_IDX, 8'h08, "stat rst");
    rdc(SSC_BAUD_IDX, 8'h03, "baud rst");
    rdc(SSC_IMASK_IDX, 8'h00, "mask rst");
    rdc(4'h9, 8'h00, "unmapped");
    chk(8'(sck_o), 8'h01, "idle clk");
    chk(8'(sck_oe_n_o), 8'h00, "clk drive");
  endtask

  task automatic t_sync_tx;
    logic [3:0] b;
    logic [7:0] s;
    b = rises;
    wr(SSC_CTRL_IDX, 8'h08);
    wr(SSC_TXD_IDX, 8'h5A);
    s = 8'h00;
    for (int i = 0; i < 60 && !s[SSC_EV_TXDONE]; i++) begin
      rd(SSC_ISTAT_IDX, s);
    end
    chk(8'(rises - b), 8'h08, "pulses");
    chk(cap, 8'h5A, "sync data");
    chk(8'(txd_o), 8'h00, "msb hold");
    chk(8'(sck_o), 8'h01, "idle clk");
    chk(8'(irq_o), 8'h00, "masked");
    wr(SSC_IMASK_IDX, 8'h08);
    repeat (2) @(negedge clk_sys_i);
    chk(8'(irq_o), 8'h01, "irq up");
    wr(SSC_ISTAT_IDX, 8'h08);
    repeat (2) @(negedge clk_sys_i);
    chk(8'(irq_o), 8'h00, "irq clr");
  endtask

  task automatic t_card_good;
    wr(SSC_CTRL_IDX, 8'h34);
    card.send_char(8'hC3, 1'b0);
    repeat (8) @(negedge clk_sys_i);
    rdc(SSC_STAT_IDX, 8'h09, "good stat");
    chk(8'(rdi), 8'h01, "rx irq");
    chk(8'(rei), 8'h00, "no err irq");
    rdc(SSC_RXD_IDX, 8'hC3, "good data");
    wr(SSC_STAT_IDX, 8'h00);
    repeat (2) @(negedge clk_sys_i);
    chk(8'(rdi), 8'h00, "rx irq clr");
  endtask

  task automatic t_card_bad;
    card.send_char(8'h96, 1'b1);
    repeat (8) @(negedge clk_sys_i);
    rdc(SSC_STAT_IDX, 8'h0A, "par stat");
    chk(8'(rei), 8'h01, "err irq");
    rdc(SSC_RXD_IDX, 8'h96, "par data");
    wr(SSC_STAT_IDX, 8'h02);
    rdc(SSC_STAT_IDX, 8'h0A, "w1 keeps");
    wr(SSC_STAT_IDX, 8'h00);
    repeat (2) @(negedge clk_sys_i);
    rdc(SSC_STAT_IDX, 8'h08, "par clr");
    chk(8'(rei), 8'h00, "err irq clr");
  endtask

  task automatic t_overrun;
    card.send_char(8'h11, 1'b0);
    repeat (8) @(negedge clk_sys_i);
    card.send_char(8'h22, 1'b0);
    repeat (8) @(negedge clk_sys_i);
    rdc(SSC_STAT_IDX, 8'h0D, "ovr stat");
    chk(8'(rei), 8'h01, "ovr irq");
    wr(SSC_STAT_IDX, 8'h00);
    wr(SSC_CTRL_IDX, 8'h14);
    card.send_char(8'h3C, 1'b1);
    repeat (8) @(negedge clk_sys_i);
    chk(8'(rei), 8'h00, "irq off");
    rdc(SSC_STAT_IDX, 8'h0A, "par no irq");
    wr(SSC_STAT_IDX, 8'h00);
  endtask

  task automatic t_ext_clk;
    wr(SSC_CTRL_IDX, 8'h02);
    repeat (2) @(negedge clk_sys_i);
    chk(8'(sck_oe_n_o), 8'h01, "ext clk");
    // External clock transfer: pin edges drive the shifter, pin stays undriven
    wr(SSC_ISTAT_IDX, 8'h0F);
    wr(SSC_CTRL_IDX, 8'h0A);
    wr(SSC_TXD_IDX, 8'hA5);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys_i);
      sck_i <= 1'b0;
      repeat (8) @(posedge clk_sys_i);
      sck_i <= 1'b1;
      repeat (8) @(posedge clk_sys_i);
    end
    rdc(SSC_ISTAT_IDX, 8'h08, "ext done");
    chk(8'(txd_o), 8'h01, "ext msb hold");
    chk(8'(sck_oe_n_o), 8'h01, "ext undriven");
    chk(8'(sck_o), 8'h01, "ext out high");
    wr(SSC_CTRL_IDX, 8'h00);
    repeat (2) @(negedge clk_sys_i);
    chk(8'(sck_oe_n_o), 8'h00, "int clk");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Ceiling well above the roughly 4000 cycles the scenarios need
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      wrap_up();
    end
  end

  initial begin
    clk_sys_i = 1'b0;
    sys_rst_i = 1'b1;
    reg_addr_i = 4'h0;
    reg_wdata_i = 8'h00;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    sck_i = 1'b1;
    err_count = 0;
    n_tests = 0;
    cyc = 0;
    repeat (12) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_sync_tx();
    t_card_good();
    t_card_bad();
    t_overrun();
    t_ext_clk();
    wrap_up();
  end
endmodule
`default_nettype wire
